//--- hdl/io_pd_pkg.sv
// Constants and types shared by the process data mapper
// Functional notes
// - One 16-bit status word of input states, one 16-bit control word of outputs.
// - Channel A input state appears in status word and in its port sub-slot byte.
// - Control word drives the channel B digital outputs.
// - By default channel A output follows bit 0 of sub-slot output byte 1.
// - With source select set, channel A takes the control word; one source only.
// - High byte of each word travels first, at the lower address.
// - Layout 1: high byte ports 8..5 B/A interleaved, low byte ports 4..1.
// - Layout 2: same interleaving, high byte ports 4..1, low byte ports 8..5.
// - Layout 3: high byte channel B ports 8..1, low byte channel A.
// - Layout 4: high byte channel A ports 8..1, low byte channel B.
// - Layout 5: each bit position follows a user-configured port channel.
// - Diagnostics of port n, both pins, report on diagnostic channel n.
// - Sub-slot lengths configurable: 1..33 input bytes, 1..32 output bytes.
// - Qualifier byte is appended as the last byte of port input data.
// - Digital input port: one byte, state in bit 0, copied to status word.
// - Selected layout never changes sub-slot process data.
// - Qualifier bits 0 and 1 read 0; bits 2 and 3 unsupported.
// - Qualifier bit 4 set while port active, cleared after port deactivation.
// - Qualifier bit 5 set when device in preoperate or operate state.
// - Qualifier bit 6 set while an error or warning is assigned.
// - Qualifier bit 7 set when device input data are valid.
// - Status/control is sub-slot 1, always present; ports are sub-slots 2..9.
package io_pd_pkg;
	localparam int PORT_COUNT = 8;
	localparam int DEV_BYTES_MAX = 32;
	localparam logic [5:0] LEN_MIN = 6'h01;
	localparam logic [5:0] IN_LEN_MAX = 6'h21;
	localparam logic [5:0] OUT_LEN_MAX = 6'h20;
	localparam logic [5:0] FIRST_BYTE = 6'h00;
	localparam logic [3:0] SUBSLOT_STATUS = 4'h1;
	localparam logic [3:0] SUBSLOT_FIRST_PORT = 4'h2;
	localparam int DIO_BIT_POS = 0;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [7:0] PORT_BITS_RESET = 8'h00;
	localparam logic OPERATING_RESET = 1'b1;

	typedef enum logic [2:0] {
		LAYOUT_1 = 3'b001,
		LAYOUT_2 = 3'b010,
		LAYOUT_3 = 3'b011,
		LAYOUT_4 = 3'b100,
		LAYOUT_5 = 3'b101
	} layout_type;

	// Big-endian word: hi is the first byte on the fieldbus
	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
	} word_type;

	typedef struct packed {
		logic data_valid;
		logic error;
		logic communicating;
		logic operating;
		logic substitute;
		logic new_param;
		logic [1:0] reserved;
	} qualifier_type;

	localparam word_type WORD_RESET = '{hi: 8'h00, lo: 8'h00};
	localparam qualifier_type QUALIFIER_RESET = 8'h00;
endpackage

//--- hdl/io_process_data_mapper.sv
// Cyclic process data mapper between eight IO ports and the fieldbus image
`timescale 1ns/1ps
`default_nettype none
module io_process_data_mapper (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] di_a_pin,
	input wire logic [7:0] di_b_pin,
	input wire io_pd_pkg::layout_type layout_select,
	input wire logic channel_a_output_source_select,
	input wire logic [63:0] user_map,
	input wire io_pd_pkg::word_type ctrl_word,
	input wire logic ctrl_valid,
	input wire logic so_wr_en,
	input wire logic [2:0] so_wr_port,
	input wire logic [5:0] so_wr_index,
	input wire logic [7:0] so_wr_data,
	input wire logic [47:0] out_len_cfg,
	input wire logic dev_wr_en,
	input wire logic [2:0] dev_wr_port,
	input wire logic [4:0] dev_wr_index,
	input wire logic [7:0] dev_wr_data,
	input wire logic [47:0] in_len_cfg,
	input wire logic [7:0] port_is_di,
	input wire logic [7:0] port_suspend,
	input wire logic [7:0] port_resume,
	input wire logic [7:0] device_communicating_flag,
	input wire logic [7:0] port_error_flag,
	input wire logic [7:0] process_data_valid_flag,
	input wire logic [7:0] diag_a,
	input wire logic [7:0] diag_b,
	input wire logic rd_en,
	input wire logic [2:0] rd_port,
	input wire logic [5:0] rd_index,
	output io_pd_pkg::word_type status_word_ff,
	output logic [7:0] do_a_ff,
	output logic [7:0] do_b_ff,
	output logic [7:0] diag_channel_ff,
	output io_pd_pkg::qualifier_type [7:0] qualifier_ff,
	output logic [7:0] rd_data_ff,
	output logic rd_valid_ff,
	output logic [3:0] rd_subslot_ff
);
	import io_pd_pkg::*;

	logic [7:0] a_s1_ff, a_s2_ff, a_s3_ff, di_a_ff;
	logic [7:0] b_s1_ff, b_s2_ff, b_s3_ff, di_b_ff;
	word_type ctrl_ff;
	logic ctrl_seen_ff;
	logic [7:0] so_bit0_ff;
	logic [7:0] operating_ff;
	logic [7:0] in_mem [0:255];
	logic [3:0] src [0:15];
	word_type nxt_status;
	logic [7:0] nxt_ctrl_a, nxt_ctrl_b;
	logic [5:0] rd_len;
	logic rd_is_pqi;
	logic [7:0] nxt_rd_data;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Position to port/channel: {port[2:0], channel}, channel 1 is B
	function automatic logic [3:0] src_of(input layout_type l, input logic [3:0] p, input logic [63:0] m);
		case (l)
			LAYOUT_1: src_of = p;
			LAYOUT_2: src_of = p ^ 4'h8;
			LAYOUT_3: src_of = {p[2:0], p[3]};
			LAYOUT_4: src_of = {p[2:0], ~p[3]};
			LAYOUT_5: src_of = m[{p, 2'b00} +: 4];
			default: src_of = p;
		endcase
	endfunction

	// Out-of-range lengths are clamped rather than refused, so the port keeps a usable image
	function automatic logic [5:0] clamp_len(input logic [5:0] v, input logic [5:0] hi);
		if (v < LEN_MIN) begin
			clamp_len = LEN_MIN;
		end else if (v > hi) begin
			clamp_len = hi;
		end else begin
			clamp_len = v;
		end
	endfunction

	// Pin synchronisers: a change counts once stages two and three agree
	always_ff @(posedge clk) begin
		if (rst) begin
			a_s1_ff <= PORT_BITS_RESET;
			a_s2_ff <= PORT_BITS_RESET;
			a_s3_ff <= PORT_BITS_RESET;
			b_s1_ff <= PORT_BITS_RESET;
			b_s2_ff <= PORT_BITS_RESET;
			b_s3_ff <= PORT_BITS_RESET;
		end else begin
			a_s1_ff <= di_a_pin;
			a_s2_ff <= a_s1_ff;
			a_s3_ff <= a_s2_ff;
			b_s1_ff <= di_b_pin;
			b_s2_ff <= b_s1_ff;
			b_s3_ff <= b_s2_ff;
		end
	end

	generate
		for (genvar i = 0; i < PORT_COUNT; i++) begin : g_filt
			// Filtered input level per port and channel
			always_ff @(posedge clk) begin
				if (rst) begin
					di_a_ff[i] <= 1'b0;
					di_b_ff[i] <= 1'b0;
				end else begin
					if (a_s2_ff[i] == a_s3_ff[i]) begin
						di_a_ff[i] <= a_s3_ff[i];
					end
					if (b_s2_ff[i] == b_s3_ff[i]) begin
						di_b_ff[i] <= b_s3_ff[i];
					end
				end
			end
		end
	endgenerate

	// Control word capture; the seen flag opens the outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_ff <= WORD_RESET;
			ctrl_seen_ff <= 1'b0;
		end else if (ctrl_valid) begin
			ctrl_ff <= ctrl_word;
			ctrl_seen_ff <= 1'b1;
		end
	end

	// Sub-slot output byte 1 only matters for channel A; writes past the length are dropped
	always_ff @(posedge clk) begin
		if (rst) begin
			so_bit0_ff <= PORT_BITS_RESET;
		end else if (so_wr_en && so_wr_index < clamp_len(out_len_cfg[so_wr_port*6 +: 6], OUT_LEN_MAX)) begin
			if (so_wr_index == FIRST_BYTE) begin
				so_bit0_ff[so_wr_port] <= so_wr_data[DIO_BIT_POS];
			end
		end
	end

	// Port activation: resume wins over a suspend in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			operating_ff <= {PORT_COUNT{OPERATING_RESET}};
		end else begin
			operating_ff <= (operating_ff & ~port_suspend) | port_resume;
		end
	end

	// Device input bytes; the array covers 32 bytes for each of eight ports
	always_ff @(posedge clk) begin
		if (dev_wr_en) begin
			in_mem[{dev_wr_port, dev_wr_index}] <= dev_wr_data;
		end
	end

	// Map each bit position to its source and back
	always_comb begin
		nxt_status = WORD_RESET;
		nxt_ctrl_a = PORT_BITS_RESET;
		nxt_ctrl_b = PORT_BITS_RESET;
		for (int p = 0; p < 16; p++) begin
			src[p] = src_of(layout_select, p[3:0], user_map);
			nxt_status[p] = src[p][0] ? di_b_ff[src[p][3:1]] : di_a_ff[src[p][3:1]];
			if (src[p][0]) begin
				nxt_ctrl_b[src[p][3:1]] = nxt_ctrl_b[src[p][3:1]] | ctrl_ff[p];
			end else begin
				nxt_ctrl_a[src[p][3:1]] = nxt_ctrl_a[src[p][3:1]] | ctrl_ff[p];
			end
		end
	end

	// Status word and outputs, held at zero until the first control data
	always_ff @(posedge clk) begin
		if (rst || !ctrl_seen_ff) begin
			status_word_ff <= WORD_RESET;
			do_a_ff <= PORT_BITS_RESET;
			do_b_ff <= PORT_BITS_RESET;
		end else begin
			status_word_ff <= nxt_status;
			do_b_ff <= nxt_ctrl_b;
			do_a_ff <= channel_a_output_source_select ? nxt_ctrl_a : so_bit0_ff;
		end
	end

	// Port n diagnostics, either pin, land on channel n (bit n-1)
	always_ff @(posedge clk) begin
		if (rst) begin
			diag_channel_ff <= PORT_BITS_RESET;
		end else begin
			diag_channel_ff <= diag_a | diag_b;
		end
	end

	generate
		for (genvar i = 0; i < PORT_COUNT; i++) begin : g_pq
			// Qualifier byte per port; unsupported bits are driven low
			always_ff @(posedge clk) begin
				if (rst || !ctrl_seen_ff) begin
					qualifier_ff[i] <= QUALIFIER_RESET;
				end else begin
					qualifier_ff[i].reserved <= 2'b00;
					qualifier_ff[i].new_param <= 1'b0;
					qualifier_ff[i].substitute <= 1'b0;
					qualifier_ff[i].operating <= operating_ff[i];
					qualifier_ff[i].communicating <= device_communicating_flag[i];
					qualifier_ff[i].error <= port_error_flag[i] | diag_a[i] | diag_b[i];
					qualifier_ff[i].data_valid <= process_data_valid_flag[i];
				end
			end
		end
	endgenerate

	// Sub-slot input read; the layout plays no part here
	always_comb begin
		rd_len = clamp_len(in_len_cfg[rd_port*6 +: 6], IN_LEN_MAX);
		rd_is_pqi = !port_is_di[rd_port] && (rd_index == rd_len - 6'h01);
		nxt_rd_data = BYTE_RESET;
		if (port_is_di[rd_port]) begin
			if (rd_index == FIRST_BYTE && ctrl_seen_ff) begin
				nxt_rd_data[DIO_BIT_POS] = di_a_ff[rd_port];
			end
		end else if (rd_is_pqi) begin
			nxt_rd_data = qualifier_ff[rd_port];
		end else if (rd_index < rd_len - 6'h01) begin
			nxt_rd_data = in_mem[{rd_port, rd_index[4:0]}];
		end
	end

	// One-cycle read answer, tagged with the sub-slot number 2..9
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_data_ff <= BYTE_RESET;
			rd_valid_ff <= 1'b0;
			rd_subslot_ff <= SUBSLOT_STATUS;
		end else begin
			rd_valid_ff <= rd_en;
			if (rd_en) begin
				rd_data_ff <= nxt_rd_data;
				rd_subslot_ff <= SUBSLOT_FIRST_PORT + {1'b0, rd_port};
			end
		end
	end

	l1_layout_a: assert property (ctrl_seen_ff && layout_select == LAYOUT_1 |=>
		status_word_ff.hi[1:0] == {$past(di_b_ff[4]), $past(di_a_ff[4])}) else $error("layout 1 high byte wrong");
	l2_layout_a: assert property (ctrl_seen_ff && layout_select == LAYOUT_2 |=>
		status_word_ff.hi[1:0] == {$past(di_b_ff[0]), $past(di_a_ff[0])}) else $error("layout 2 high byte wrong");
	l3_layout_a: assert property (ctrl_seen_ff && layout_select == LAYOUT_3 |=>
		status_word_ff == {$past(di_b_ff), $past(di_a_ff)}) else $error("layout 3 word wrong");
	l4_layout_a: assert property (ctrl_seen_ff && layout_select == LAYOUT_4 |=>
		status_word_ff == {$past(di_a_ff), $past(di_b_ff)}) else $error("layout 4 word wrong");
	chb_control_a: assert property (ctrl_seen_ff && layout_select == LAYOUT_3 |=>
		do_b_ff == $past(ctrl_ff.hi)) else $error("channel B not from control word");
	cha_ctrl_src_a: assert property (ctrl_seen_ff && channel_a_output_source_select && layout_select == LAYOUT_4 |=>
		do_a_ff == $past(ctrl_ff.hi)) else $error("channel A not from control word");
	cha_subslot_a: assert property (ctrl_seen_ff && !channel_a_output_source_select |=>
		do_a_ff == $past(so_bit0_ff)) else $error("channel A not from sub-slot bit 0");
	diag_channel_a: assert property (1'b1 |=> diag_channel_ff == $past(diag_a | diag_b)) else $error("diagnostic channel wrong");
	pq_low_bits_a: assert property (qualifier_ff[rd_port][3:0] == 4'h0) else $error("qualifier low bits set");
	pq_suspend_a: assert property (ctrl_seen_ff && port_suspend[0] && !port_resume[0] ##1 !port_resume[0] |=>
		!qualifier_ff[0].operating) else $error("operating bit still set after suspend");
	pq_read_a: assert property (rd_en && rd_is_pqi |=>
		rd_valid_ff && rd_data_ff == $past(qualifier_ff[rd_port])) else $error("qualifier not last byte");
	quiet_reset_a: assert property (!ctrl_seen_ff |->
		do_a_ff == 8'h00 && do_b_ff == 8'h00 && status_word_ff == WORD_RESET) else $error("outputs active before control data");

	first_ctrl_c: cover property (!ctrl_seen_ff ##1 ctrl_seen_ff);
	user_layout_c: cover property (ctrl_seen_ff && layout_select == LAYOUT_5 && status_word_ff != WORD_RESET);
	suspend_resume_c: cover property (port_suspend[0] ##[1:20] port_resume[0]);
	pqi_read_c: cover property (rd_en && rd_is_pqi && rd_len == IN_LEN_MAX);
endmodule
`default_nettype wire

//--- test/io_process_data_mapper_tb.sv
// Self-checking bench for the process data mapper
`timescale 1ns/1ps
`default_nettype none
module io_process_data_mapper_tb;
	import io_pd_pkg::*;
	logic clk = 1'b0, rst = 1'b1, channel_a_output_source_select = 1'b1, ctrl_valid, rd_en, rd_valid_ff;
	logic so_wr_en = 1'b0, dev_wr_en = 1'b0;
	logic [7:0] di_a_pin = 8'hc5, di_b_pin = 8'h3a, port_is_di = 8'h00, port_suspend = 8'h00, port_resume = 8'h00;
	logic [7:0] device_communicating_flag = 8'h00, port_error_flag = 8'h00, process_data_valid_flag = 8'h00;
	logic [7:0] diag_a = 8'h00, diag_b = 8'h00, so_wr_data = 8'h00, dev_wr_data = 8'h00;
	logic [7:0] do_a_ff, do_b_ff, diag_channel_ff, rd_data_ff, rd_d;
	logic [2:0] so_wr_port = 3'h0, dev_wr_port = 3'h0, rd_port;
	logic [5:0] so_wr_index = 6'h00, rd_index;
	logic [4:0] dev_wr_index = 5'h00;
	logic [47:0] in_len_cfg, out_len_cfg;
	logic [63:0] user_map = 64'h00ff_1032_5476_98ba;
	logic [3:0] rd_subslot_ff, rd_sub;
	logic rd_ok;
	layout_type layout_select = LAYOUT_1;
	word_type ctrl_word, status_word_ff;
	qualifier_type [7:0] qualifier_ff;
	int fails = 0, tests_run = 0;
	always #10 clk = ~clk;
	io_process_data_mapper i_dut (.clk, .rst, .di_a_pin, .di_b_pin, .layout_select, .channel_a_output_source_select,
		.user_map, .ctrl_word, .ctrl_valid, .so_wr_en, .so_wr_port, .so_wr_index, .so_wr_data, .out_len_cfg,
		.dev_wr_en, .dev_wr_port, .dev_wr_index, .dev_wr_data, .in_len_cfg, .port_is_di, .port_suspend,
		.port_resume, .device_communicating_flag, .port_error_flag, .process_data_valid_flag, .diag_a, .diag_b,
		.rd_en, .rd_port, .rd_index, .status_word_ff, .do_a_ff, .do_b_ff, .diag_channel_ff, .qualifier_ff,
		.rd_data_ff, .rd_valid_ff, .rd_subslot_ff);
	plc_model i_plc (.clk, .ctrl_word, .ctrl_valid, .in_len_cfg, .out_len_cfg, .rd_en, .rd_port, .rd_index,
		.rd_data_ff, .rd_valid_ff, .rd_subslot_ff);
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		chk_word({8'h00, got}, {8'h00, exp}, what);
	endtask
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Read with a bounded answer wait; a silent design counts as a mismatch
	task automatic rd(input logic [2:0] port, input logic [5:0] idx, input logic [7:0] exp);
		i_plc.read_byte(port, idx, rd_d, rd_sub, rd_ok);
		chk_byte({7'h00, rd_ok}, 8'h01, "read answer");
		chk_byte(rd_d, exp, "read data");
		chk_byte({4'h0, rd_sub}, {4'h0, port} + 8'h02, "read subslot");
	endtask
	// Every layout: status from pins, control word back to both channels
	// Expected words worked out by hand for pins a=c5, b=3a and the user map above
	task automatic t_layouts();
		layout_type tbl[5] = '{LAYOUT_1, LAYOUT_2, LAYOUT_3, LAYOUT_4, LAYOUT_5};
		logic [15:0] ctl[5] = '{16'ha54d, 16'ha44d, 16'ha74d, 16'ha64d, 16'ha14d};
		logic [15:0] sts[5] = '{16'h5a99, 16'h995a, 16'h3ac5, 16'hc53a, 16'hc66a};
		logic [7:0] cha[5] = '{8'h3b, 8'hb2, 8'h4d, 8'ha6, 8'h37};
		logic [7:0] chb[5] = '{8'hc2, 8'h2c, 8'ha7, 8'h4d, 8'h90};
		foreach (tbl[k]) begin
			layout_select = tbl[k];
			i_plc.send_word(ctl[k]);
			repeat (6) @(negedge clk);
			chk_byte(status_word_ff.hi, sts[k][15:8], "status high byte first");
			chk_word(status_word_ff, sts[k], "status word");
			chk_byte(do_b_ff, chb[k], "channel B outputs");
			chk_byte(do_a_ff, cha[k], "channel A from control word");
		end
	endtask
	task automatic so_wr(input logic [2:0] port, input logic [5:0] idx, input logic [7:0] d);
		@(negedge clk);
		{so_wr_en, so_wr_port, so_wr_index, so_wr_data} = {1'b1, port, idx, d};
		@(negedge clk);
		so_wr_en = 1'b0;
	endtask
	// Sub-slot bit 0 drives channel A unless the control word is selected
	task automatic t_subslot();
		layout_select = LAYOUT_3;
		channel_a_output_source_select = 1'b0;
		i_plc.send_word(16'h00ff);
		so_wr(3'h2, 6'h00, 8'h01);
		so_wr(3'h4, 6'h00, 8'hfe);
		so_wr(3'h1, 6'h01, 8'h01);
		repeat (4) @(negedge clk);
		chk_byte(do_a_ff, 8'h04, "channel A from sub-slot");
		channel_a_output_source_select = 1'b1;
		repeat (4) @(negedge clk);
		chk_byte(do_a_ff, 8'hff, "channel A back on control word");
	endtask
	task automatic dev_wr(input logic [2:0] port, input logic [4:0] idx, input logic [7:0] d);
		@(negedge clk);
		{dev_wr_en, dev_wr_port, dev_wr_index, dev_wr_data} = {1'b1, port, idx, d};
		@(negedge clk);
		dev_wr_en = 1'b0;
	endtask
	// Qualifier flags, appended qualifier byte and the longest input length
	task automatic t_qualifier();
		i_plc.set_len(3'h0, 6'h03, 6'h02);
		i_plc.set_len(3'h7, 6'h3f, 6'h20);
		dev_wr(3'h0, 5'h00, 8'h3c);
		dev_wr(3'h0, 5'h01, 8'hc3);
		dev_wr(3'h7, 5'h1f, 8'h9e);
		process_data_valid_flag = 8'h01;
		device_communicating_flag = 8'h01;
		repeat (3) @(negedge clk);
		chk_byte(qualifier_ff[0], 8'hb0, "qualifier valid");
		rd(3'h0, 6'h00, 8'h3c);
		rd(3'h0, 6'h01, 8'hc3);
		rd(3'h0, 6'h02, 8'hb0);
		rd(3'h0, 6'h03, 8'h00);
		rd(3'h7, 6'h1f, 8'h9e);
		rd(3'h7, 6'h20, 8'h10);
		port_error_flag = 8'h01;
		repeat (3) @(negedge clk);
		chk_byte(qualifier_ff[0], 8'hf0, "qualifier error");
		{port_error_flag, process_data_valid_flag, device_communicating_flag} = 24'h0;
		port_suspend = 8'h01;
		@(negedge clk);
		port_suspend = 8'h00;
		repeat (3) @(negedge clk);
		chk_byte(qualifier_ff[0], 8'h00, "qualifier suspended");
		port_resume = 8'h01;
		@(negedge clk);
		port_resume = 8'h00;
		repeat (3) @(negedge clk);
		chk_byte(qualifier_ff[0], 8'h10, "qualifier resumed");
	endtask
	// Digital input port byte follows its pin under layouts 3 and 4, then diagnostic channels
	task automatic t_di_diag();
		port_is_di = 8'h02;
		di_a_pin = 8'h02;
		repeat (8) @(negedge clk);
		rd(3'h1, 6'h00, 8'h01);
		layout_select = LAYOUT_4;
		di_a_pin = 8'h00;
		repeat (8) @(negedge clk);
		chk_byte(status_word_ff.hi, 8'h00, "status follows input");
		rd(3'h1, 6'h00, 8'h00);
		diag_a = 8'h05;
		diag_b = 8'h90;
		repeat (2) @(negedge clk);
		chk_byte(diag_channel_ff, 8'h95, "diagnostic channels");
	endtask
	initial begin
		repeat (12) @(negedge clk);
		rst = 1'b0;
		repeat (10) @(negedge clk);
		chk_word(status_word_ff, 16'h0000, "status before control");
		chk_word({do_a_ff, do_b_ff}, 16'h0000, "outputs before control");
		chk_byte(qualifier_ff[0] | qualifier_ff[7], 8'h00, "qualifier before control");
		t_layouts();
		t_subslot();
		t_qualifier();
		t_di_diag();
		stop_test();
	end
endmodule
`default_nettype wire

//--- test/plc_model.sv
// Behavioural fieldbus controller that trades cyclic data with the mapper
`timescale 1ns/1ps
`default_nettype none
module plc_model (
	input wire logic clk,
	output io_pd_pkg::word_type ctrl_word,
	output logic ctrl_valid,
	output logic [47:0] in_len_cfg,
	output logic [47:0] out_len_cfg,
	output logic rd_en,
	output logic [2:0] rd_port,
	output logic [5:0] rd_index,
	input wire logic [7:0] rd_data_ff,
	input wire logic rd_valid_ff,
	input wire logic [3:0] rd_subslot_ff
);
	import io_pd_pkg::*;
	// Idle controller with every port at the smallest length
	initial begin
		ctrl_word = WORD_RESET;
		ctrl_valid = 1'b0;
		in_len_cfg = {8{6'h01}};
		out_len_cfg = {8{6'h01}};
		rd_en = 1'b0;
		rd_port = 3'h0;
		rd_index = 6'h00;
	end
	// Lengths are written as given; the mapper clamps out-of-range values
	task automatic set_len(input logic [2:0] port, input logic [5:0] in_len, input logic [5:0] out_len);
		@(negedge clk);
		in_len_cfg[port*6 +: 6] = in_len;
		out_len_cfg[port*6 +: 6] = out_len;
	endtask
	// Stale word lines are scrambled so only the strobed cycle carries data
	task automatic send_word(input word_type w);
		@(negedge clk);
		ctrl_word = w;
		ctrl_valid = 1'b1;
		@(negedge clk);
		ctrl_valid = 1'b0;
		ctrl_word = ~w;
	endtask
	// One sub-slot byte read; ok stays low when no answer comes in time
	task automatic read_byte(input logic [2:0] port, input logic [5:0] idx, output logic [7:0] d,
		output logic [3:0] sub, output logic ok);
		ok = 1'b0;
		d = 8'h00;
		sub = 4'h0;
		@(negedge clk);
		rd_en = 1'b1;
		rd_port = port;
		rd_index = idx;
		for (int i = 0; i < 4 && !ok; i++) begin
			@(negedge clk);
			rd_en = 1'b0;
			rd_index = ~idx;
			if (rd_valid_ff === 1'b1) begin
				ok = 1'b1;
				d = rd_data_ff;
				sub = rd_subslot_ff;
			end
		end
	endtask
endmodule
`default_nettype wire
